// ---- core/ssc_clk_irq.sv ----
// bit-clock prescaler, receive timeout and interrupt enable logic
// assumes fifo flags and strobes come from logic on i_sys_clk;
// the slave clock pin is asynchronous and is synchronised here
`timescale 1ns/1ps

// How it works
// - prescaler divides system clock by even divisor from 2 to 254
// - prescale divisor bit 0 is never stored and reads as zero
// - bit clock is prescaled clock divided again by rate factor plus one
// - slave mode ignores divisor and rate factor, uses incoming clock
// - four enable bits, one each condition, reset to zero
// - overrun latched when frame completes while receive fifo full
// - on overrun the fifo is told to overwrite the newest entry
// - timeout after 32 bit times with data waiting and no activity
// - receive level condition while receive fifo at least half full
// - transmit level condition while transmit fifo at least half empty
// - masked status is raw status and enables, raw ignores enables
// - clear strobes drop overrun and timeout, levels follow fifos
module ssc_clk_irq (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [31:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_serial_clock_rate_factor,
  input wire logic i_slave_mode,
  input wire logic i_slave_sclk,
  input wire logic i_rx_frame_done,
  input wire logic i_rx_fifo_full,
  input wire logic i_rx_fifo_not_empty,
  input wire logic i_rx_fifo_read,
  input wire logic i_rx_half_full,
  input wire logic i_tx_half_empty,
  input wire logic i_clear_overrun,
  input wire logic i_clear_timeout,
  output logic o_bit_tick,
  output logic o_rx_overwrite,
  output logic [3:0] o_raw_status,
  output logic [3:0] o_masked_status,
  output logic o_irq
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:1] prescale_divisor_q;
  logic [3:0] interrupt_enable_q, interrupt_enable_d;
  logic wr_prescale, wr_enable;
  logic [7:0] divisor;

  assign wr_prescale = i_reg_wr &&
    (i_reg_addr == ssc_pkg::CLOCK_PRESCALE_ADDR);
  assign wr_enable = i_reg_wr &&
    (i_reg_addr == ssc_pkg::INTERRUPT_ENABLE_ADDR);
  assign divisor = {prescale_divisor_q, 1'b0};
  assign interrupt_enable_d = wr_enable ? i_reg_wdata[3:0] :
    interrupt_enable_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prescale_divisor_q <= ssc_pkg::CLOCK_PRESCALE_RESET[7:1];
    end else if (i_clk_en && wr_prescale) begin
      prescale_divisor_q <= i_reg_wdata[7:1];
    end
  end

  // enable bits, reserved bits not stored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      interrupt_enable_q <= ssc_pkg::INTERRUPT_ENABLE_RESET;
    end else if (i_clk_en) begin
      interrupt_enable_q <= interrupt_enable_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= ssc_pkg::READ_UNMAPPED;
    end else if (i_clk_en && i_reg_rd) begin
      if (i_reg_addr == ssc_pkg::CLOCK_PRESCALE_ADDR) begin
        o_reg_rdata <= divisor;
      end else if (i_reg_addr == ssc_pkg::INTERRUPT_ENABLE_ADDR) begin
        o_reg_rdata <= {4'h0, interrupt_enable_q};
      end else begin
        o_reg_rdata <= ssc_pkg::READ_UNMAPPED;
      end
    end
  end

  // ------------------------------------------------------------
  // bit clock
  // ------------------------------------------------------------
  logic [7:0] psc_cnt_q, rate_cnt_q;
  logic [2:0] sclk_sync_q;
  logic psc_tick, master_tick, slave_edge, bit_tick;

  // a divisor of zero means not yet set up: no master-mode ticks at all
  assign psc_tick = !i_slave_mode && (divisor != 8'h00) &&
    (psc_cnt_q == divisor - 8'h01);
  assign master_tick = psc_tick && (rate_cnt_q >= i_serial_clock_rate_factor);
  // only the second and third stages feed the edge detect
  assign slave_edge = sclk_sync_q[1] && !sclk_sync_q[2];
  assign bit_tick = i_slave_mode ? slave_edge : master_tick;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      psc_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (psc_tick || i_slave_mode || wr_prescale) begin
        psc_cnt_q <= 8'h00;
      end else if (divisor != 8'h00) begin
        psc_cnt_q <= psc_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rate_cnt_q <= 8'h00;
    end else if (i_clk_en) begin
      if (i_slave_mode || master_tick) begin
        rate_cnt_q <= 8'h00;
      end else if (psc_tick) begin
        rate_cnt_q <= rate_cnt_q + 8'h01;
      end
    end
  end

  // sync is fast enough only up to a quarter of the clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_sync_q <= 3'h0;
    end else if (i_clk_en) begin
      sclk_sync_q <= {sclk_sync_q[1:0], i_slave_sclk};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bit_tick <= 1'b0;
    end else if (i_clk_en) begin
      o_bit_tick <= bit_tick;
    end
  end

  // ------------------------------------------------------------
  // interrupt conditions
  // ------------------------------------------------------------
  logic overrun_q, timeout_q;
  logic [5:0] idle_cnt_q;
  logic overrun_set, timeout_set, rx_activity;
  logic [3:0] raw_d;

  assign overrun_set = i_rx_frame_done && i_rx_fifo_full;
  assign rx_activity = i_rx_frame_done || i_rx_fifo_read ||
    !i_rx_fifo_not_empty;
  assign timeout_set = !rx_activity && bit_tick &&
    (idle_cnt_q == ssc_pkg::TIMEOUT_BIT_TIMES - 6'h01);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idle_cnt_q <= 6'h00;
    end else if (i_clk_en) begin
      if (rx_activity) begin
        idle_cnt_q <= 6'h00;
      end else if (bit_tick && idle_cnt_q != ssc_pkg::TIMEOUT_BIT_TIMES) begin
        idle_cnt_q <= idle_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      overrun_q <= 1'b0;
    end else if (i_clk_en) begin
      if (overrun_set) begin
        overrun_q <= 1'b1;
      end else if (i_clear_overrun) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // clear strobe or fresh data drops timeout
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timeout_q <= 1'b0;
    end else if (i_clk_en) begin
      if (timeout_set) begin
        timeout_q <= 1'b1;
      end else if (i_clear_timeout || i_rx_frame_done) begin
        timeout_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_overwrite <= 1'b0;
    end else if (i_clk_en) begin
      o_rx_overwrite <= overrun_set;
    end
  end

  always_comb begin
    raw_d = 4'h0;
    raw_d[ssc_pkg::IRQ_OVERRUN] = overrun_set ||
      (overrun_q && !i_clear_overrun);
    raw_d[ssc_pkg::IRQ_TIMEOUT] = timeout_set ||
      (timeout_q && !i_clear_timeout && !i_rx_frame_done);
    raw_d[ssc_pkg::IRQ_RX_LEVEL] = i_rx_half_full;
    raw_d[ssc_pkg::IRQ_TX_LEVEL] = i_tx_half_empty;
  end

  // status and request from next state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_raw_status <= 4'h0;
      o_masked_status <= 4'h0;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_raw_status <= raw_d;
      o_masked_status <= raw_d & interrupt_enable_d;
      o_irq <= |(raw_d & interrupt_enable_d);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_overrun_event;
    i_clk_en && overrun_set;
  endsequence
  sequence s_overrun_seen;
    o_raw_status[ssc_pkg::IRQ_OVERRUN] && o_rx_overwrite;
  endsequence

  chk_prescale_low_zero: assert property (
    $past(i_clk_en && i_reg_rd &&
          i_reg_addr == ssc_pkg::CLOCK_PRESCALE_ADDR) |-> !o_reg_rdata[0])
    else $error("prescale readback low bit set");
  chk_master_div_two: assert property (
    i_clk_en && !i_slave_mode && divisor == ssc_pkg::PRESCALE_MIN &&
    i_serial_clock_rate_factor == 8'h00 && master_tick &&
    !wr_prescale ##1 i_clk_en && !i_slave_mode && !wr_prescale
    |-> !master_tick ##1 master_tick)
    else $error("divide by two period wrong");
  chk_rate_needs_psc: assert property (
    i_clk_en && psc_tick && !master_tick
    |=> rate_cnt_q == $past(rate_cnt_q) + 8'h01)
    else $error("rate count did not advance");
  chk_slave_no_psc: assert property (
    i_clk_en && i_slave_mode |=> psc_cnt_q == 8'h00 && rate_cnt_q == 8'h00)
    else $error("prescaler active in slave mode");
  chk_enable_reset: assert property (
    $rose(i_reset_n) |-> interrupt_enable_q == 4'h0)
    else $error("enables not cleared by reset");
  chk_overrun_latch: assert property (
    s_overrun_event |=> s_overrun_seen)
    else $error("overrun not reported");
  chk_timeout_raise: assert property (
    i_clk_en && timeout_set |=> o_raw_status[ssc_pkg::IRQ_TIMEOUT])
    else $error("timeout not raised");
  chk_timeout_quiet: assert property (
    i_clk_en && rx_activity |=> idle_cnt_q == 6'h00)
    else $error("idle count not restarted");
  chk_masked_subset: assert property (
    (o_masked_status & ~interrupt_enable_q) == 4'h0 &&
    (o_masked_status & ~o_raw_status) == 4'h0)
    else $error("masked status outside raw and enables");
  chk_clear_overrun: assert property (
    i_clk_en && i_clear_overrun && !overrun_set
    |=> !o_raw_status[ssc_pkg::IRQ_OVERRUN])
    else $error("overrun clear ignored");
  chk_irq_level: assert property (
    o_irq == (o_masked_status != 4'h0))
    else $error("irq disagrees with masked status");
endmodule

// ---- shared/ssc_pkg.sv ----
// constants of the serial-port bit-clock prescaler and interrupt enables
// assumes the register port carries full byte addresses
package ssc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [31:0] CLOCK_PRESCALE_ADDR = 32'he0068010;
  localparam logic [31:0] INTERRUPT_ENABLE_ADDR = 32'he0068014;
  localparam logic [7:0] CLOCK_PRESCALE_RESET = 8'h00;
  localparam logic [3:0] INTERRUPT_ENABLE_RESET = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // ------------------------------------------------------------
  // interrupt condition bit positions
  // ------------------------------------------------------------
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_RX_LEVEL = 2;
  localparam int IRQ_TX_LEVEL = 3;
  localparam int IRQ_COUNT = 4;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [5:0] TIMEOUT_BIT_TIMES = 6'h20;
  localparam logic [7:0] PRESCALE_MIN = 8'h02;
endpackage

// ---- testbench/ssc_ext_master.sv ----
// external serial master model driving the slave clock pin
// assumes i_go changes on the falling edge of i_sys_clk
`timescale 1ns/1ps
module ssc_ext_master (
  input wire logic i_sys_clk,
  input wire logic i_go,
  output logic o_sclk
);
  int cnt_q;
  // twelfth of sys clock
  // half period of six cycles; clock stands low between frames
  always_ff @(posedge i_sys_clk) begin
    if (!i_go) begin
      cnt_q <= 0;
      o_sclk <= 1'b0;
    end else if (cnt_q == 5) begin
      cnt_q <= 0;
      o_sclk <= ~o_sclk;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the prescaler and interrupt enables
// assumes ssc_pkg and the external master model are compiled first
`timescale 1ns/1ps
module tb;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [7:0] wdata = 8'h00, rate = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, smode = 1'b0, go = 1'b0, fdone = 1'b0;
  logic full = 1'b0, nempty = 1'b0, fread = 1'b0, rxh = 1'b0, txh = 1'b0;
  logic clr_o = 1'b0, clr_t = 1'b0, sclk, tick, ovw, irq;
  logic [3:0] raw, msk;
  int fails = 0, num_checks = 0, cyc = 0, ticks = 0;
  int en_m = 0, raw_m = 0, d, r, t0;

  ssc_clk_irq uut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_clk_en(1'b1), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_serial_clock_rate_factor(rate), .i_slave_mode(smode),
    .i_slave_sclk(sclk), .i_rx_frame_done(fdone), .i_rx_fifo_full(full),
    .i_rx_fifo_not_empty(nempty), .i_rx_fifo_read(fread),
    .i_rx_half_full(rxh), .i_tx_half_empty(txh),
    .i_clear_overrun(clr_o), .i_clear_timeout(clr_t), .o_bit_tick(tick),
    .o_rx_overwrite(ovw), .o_raw_status(raw), .o_masked_status(msk),
    .o_irq(irq));
  ssc_ext_master ext (.i_sys_clk(i_sys_clk), .i_go(go), .o_sclk(sclk));

  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // cycle ceiling well above the few thousand cycles the tests need
  always @(posedge i_sys_clk) begin
    cyc++;
    if (tick === 1'b1) ticks++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] seen,
      input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic reg_wr(input logic [31:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cycles(1);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [31:0] a, input logic [7:0] exp,
      input string n);
    addr = a;
    rd = 1'b1;
    cycles(1);
    rd = 1'b0;
    check(n, rdata, exp);
  endtask
  task automatic chk_st();
    check("raw", {4'h0, raw}, 8'(raw_m));
    check("masked", {4'h0, msk}, 8'(raw_m & en_m));
    check("irq", {7'h0, irq}, 8'((raw_m & en_m) != 0));
  endtask
  task automatic gap(input int exp);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 600) begin
      cycles(1);
      n++;
    end
    cycles(1);
    n = 1;
    while (tick !== 1'b1 && n < 600) begin
      cycles(1);
      n++;
    end
    check("tick gap", 8'(n), 8'(exp));
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(84677));
    cycles(4);
    i_reset_n = 1'b1;
    reg_rd(ssc_pkg::CLOCK_PRESCALE_ADDR, 8'h00, "divisor");
    reg_rd(ssc_pkg::INTERRUPT_ENABLE_ADDR, 8'h00, "enables");
    reg_rd(32'he0068018, 8'h00, "unmapped");
    chk_st();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 2 : (i == 1) ? 255 : $urandom_range(3, 25);
      r = (i < 2) ? 0 : $urandom_range(0, 9);
      rate = 8'(r);
      // divisor set before any bit time is used
      reg_wr(ssc_pkg::CLOCK_PRESCALE_ADDR, 8'(d));
      reg_rd(ssc_pkg::CLOCK_PRESCALE_ADDR, 8'(d & 254), "divisor");
      gap((d & 254) * (r + 1));
    end
    $display("test prescaler done");
    smode = 1'b1;
    cycles(4);
    t0 = ticks;
    go = 1'b1;
    cycles(120);
    go = 1'b0;
    cycles(8);
    check("slave ticks", 8'(ticks - t0), 8'h0a);
    smode = 1'b0;
    $display("test slave done");
    for (int i = 0; i < 4; i++) begin
      en_m = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(0, 15);
      reg_wr(ssc_pkg::INTERRUPT_ENABLE_ADDR, 8'(en_m));
      reg_rd(ssc_pkg::INTERRUPT_ENABLE_ADDR, 8'(en_m), "enables");
      full = 1'b1;
      fdone = 1'b1;
      cycles(1);
      fdone = 1'b0;
      raw_m = raw_m | 1;
      check("overwrite", {7'h0, ovw}, 8'h01);
      chk_st();
      cycles(1);
      check("overwrite", {7'h0, ovw}, 8'h00);
      rxh = i[0];
      txh = i[1];
      full = 1'b0;
      cycles(1);
      raw_m = 1 + 4 * rxh + 8 * txh;
      chk_st();
      clr_o = 1'b1;
      cycles(1);
      clr_o = 1'b0;
      raw_m = raw_m & 12;
      chk_st();
    end
    $display("test events done");
    // mid-run reset clears enables and divisor
    i_reset_n = 1'b0;
    cycles(2);
    i_reset_n = 1'b1;
    en_m = 0;
    raw_m = 12;
    reg_rd(ssc_pkg::INTERRUPT_ENABLE_ADDR, 8'h00, "enables");
    reg_rd(ssc_pkg::CLOCK_PRESCALE_ADDR, 8'h00, "divisor");
    chk_st();
    fdone = 1'b1;
    cycles(1);
    fdone = 1'b0;
    check("overwrite", {7'h0, ovw}, 8'h00);
    chk_st();
    en_m = 15;
    reg_wr(ssc_pkg::INTERRUPT_ENABLE_ADDR, 8'(en_m));
    $display("test reset again done");
    rate = 8'h00;
    reg_wr(ssc_pkg::CLOCK_PRESCALE_ADDR, 8'h02);
    nempty = 1'b1;
    cycles(50);
    chk_st();
    fread = 1'b1;
    cycles(1);
    fread = 1'b0;
    cycles(50);
    chk_st();
    cycles(30);
    raw_m = raw_m | 2;
    chk_st();
    clr_t = 1'b1;
    cycles(1);
    clr_t = 1'b0;
    raw_m = raw_m & 13;
    chk_st();
    nempty = 1'b0;
    $display("test timeout done");
    complete_run();
  end
endmodule
